//--- hw/sacc_conv_ctrl.v
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "sacc_consts.vh"
// ******************************
// converter sequencer and registers
// ******************************
module sacc_conv_ctrl
(
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  // analog front end
  input wire rcClock,
  input wire compareIn,
  output reg [1:0] referenceSelect,
  output reg [3:0] channelSelect,
  output reg holdConnect,
  output reg [7:0] trialCode,
  output reg converterOn,
  // status
  output reg convBusy,
  output reg irqRequest
);
  // states, one-hot
  localparam ST_IDLE = 4'h1;
  localparam ST_CONV = 4'h2;
  localparam ST_DISC = 4'h4;
  localparam ST_ABORT = 4'h8;

  reg [7:0] control_reg;
  reg [7:0] config_reg;
  reg [7:0] result_reg;
  reg flag_reg;
  reg irqEnable_reg;
  reg globalEn_reg;
  reg periphEn_reg;
  reg [3:0] state_reg;
  reg [4:0] halfCnt_reg;
  reg [7:0] sar_reg;
  reg [2:0] bitIdx_reg;
  reg compSync1_reg;
  reg compSync2_reg;
  wire halfTick;
  wire ctlWrite;
  wire startReq;
  wire abortReq;
  wire finishConv;
  wire decideBit;

  // ******************************
  // conversion tick
  // ******************************
  sacc_tick_gen u_tick
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clockSelect(control_reg[`SACC_CTL_CLKHI:`SACC_CTL_CLKLO]),
    .rcClock(rcClock),
    .halfTick(halfTick)
  );

  // write decode and end of conversion
  assign ctlWrite = regWrite && (regAddr == `SACC_ADDR_CONTROL);
  assign startReq = ctlWrite && regWdata[`SACC_CTL_START] &&
    regWdata[`SACC_CTL_ENABLE] && control_reg[`SACC_CTL_ENABLE] &&
    (state_reg == ST_IDLE);
  assign abortReq = (state_reg == ST_CONV) && ctlWrite &&
    !(regWdata[`SACC_CTL_START] && regWdata[`SACC_CTL_ENABLE]);
  assign finishConv = (state_reg == ST_CONV) && halfTick &&
    (halfCnt_reg + 5'h01 == `SACC_HALF_TICKS);
  // bits decided on full ticks 2..9 after start
  assign decideBit = (state_reg == ST_CONV) && halfTick &&
    halfCnt_reg[0] && (halfCnt_reg >= 5'h03) &&
    (halfCnt_reg <= 5'h11);

  // comparator synchroniser
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      compSync1_reg <= 1'b0;
      compSync2_reg <= 1'b0;
    end
    else
    begin
      compSync1_reg <= compareIn;
      compSync2_reg <= compSync1_reg;
    end
  end

  // ******************************
  // registers and sequencer
  // ******************************
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      control_reg <= `SACC_RESET_CTL;
      config_reg <= `SACC_RESET_CFG;
      result_reg <= 8'h00;
      flag_reg <= 1'b0;
      irqEnable_reg <= 1'b0;
      globalEn_reg <= 1'b0;
      periphEn_reg <= 1'b0;
      state_reg <= ST_IDLE;
      halfCnt_reg <= 5'h00;
      sar_reg <= 8'h00;
      bitIdx_reg <= 3'h7;
    end
    else
    begin
      // plain register writes
      if (regWrite && regAddr == `SACC_ADDR_CONFIG)
        config_reg <= regWdata & 8'h30;
      if (regWrite && regAddr == `SACC_ADDR_IRQEN)
        irqEnable_reg <= regWdata[`SACC_IRQEN_BIT];
      if (regWrite && regAddr == `SACC_ADDR_GLOBAL)
      begin
        globalEn_reg <= regWdata[`SACC_GIE_BIT];
        periphEn_reg <= regWdata[`SACC_PERIPHERAL_IRQ_ENABLE_BIT];
      end
      if (regWrite && regAddr == `SACC_ADDR_RESULT && !finishConv)
        result_reg <= regWdata;
      if (finishConv)
        flag_reg <= 1'b1;
      else if (regWrite && regAddr == `SACC_ADDR_FLAG)
        flag_reg <= regWdata[`SACC_FLAG_BIT];
      // control write; start bit cleared when refused, held set by hardware while converting
      if (ctlWrite)
      begin
        control_reg <= regWdata;
        if (!startReq && !(state_reg == ST_CONV && !abortReq))
          control_reg[`SACC_CTL_START] <= 1'b0;
        if (state_reg == ST_CONV && !abortReq)
          control_reg[`SACC_CTL_START] <= 1'b1;
      end
      if (finishConv)
        control_reg[`SACC_CTL_START] <= 1'b0;
      // sequencer
      case (state_reg)
        ST_IDLE:
        begin
          halfCnt_reg <= 5'h00;
          if (startReq)
          begin
            state_reg <= ST_CONV;
            sar_reg <= 8'h80;
            bitIdx_reg <= 3'h7;
          end
        end
        ST_CONV:
        begin
          if (abortReq)
          begin
            state_reg <= ST_ABORT;
            halfCnt_reg <= 5'h00;
          end
          else if (finishConv)
          begin
            result_reg <= sar_reg;
            state_reg <= ST_DISC;
            halfCnt_reg <= 5'h00;
          end
          else if (halfTick)
            halfCnt_reg <= halfCnt_reg + 5'h01;
          if (decideBit && !abortReq)
          begin
            if (!compSync2_reg)
              sar_reg[bitIdx_reg] <= 1'b0;
            if (bitIdx_reg != 3'h0)
            begin
              sar_reg[bitIdx_reg - 3'h1] <= 1'b1;
              bitIdx_reg <= bitIdx_reg - 3'h1;
            end
          end
        end
        ST_DISC:
        begin
          if (halfTick && halfCnt_reg + 5'h01 == `SACC_DISC_TICKS)
            state_reg <= ST_IDLE;
          else if (halfTick)
            halfCnt_reg <= halfCnt_reg + 5'h01;
        end
        ST_ABORT:
        begin
          if (halfTick && halfCnt_reg + 5'h01 == `SACC_ABORT_TICKS)
            state_reg <= ST_IDLE;
          else if (halfTick)
            halfCnt_reg <= halfCnt_reg + 5'h01;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ******************************
  // outputs
  // ******************************
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      regRdata <= 8'h00;
      referenceSelect <= `SACC_REF_SUPPLY;
      channelSelect <= 4'h0;
      holdConnect <= 1'b0;
      trialCode <= 8'h00;
      converterOn <= 1'b0;
      convBusy <= 1'b0;
      irqRequest <= 1'b0;
    end
    else
    begin
      // reference code passed to the mux
      referenceSelect <= config_reg[`SACC_CFG_REFHI:`SACC_CFG_REFLO];
      channelSelect <= {control_reg[`SACC_CTL_CHHI],
        control_reg[`SACC_CTL_CHLO+2:`SACC_CTL_CHLO]};
      // hold tracks input while enabled and idle, never discharged
      holdConnect <= control_reg[`SACC_CTL_ENABLE] &&
        (state_reg == ST_IDLE) && !startReq;
      trialCode <= sar_reg;
      converterOn <= control_reg[`SACC_CTL_ENABLE];
      convBusy <= (state_reg == ST_CONV) && !finishConv && !abortReq;
      irqRequest <= (flag_reg || finishConv) && irqEnable_reg &&
        periphEn_reg && globalEn_reg;
      regRdata <= 8'h00;
      if (regRead)
      begin
        case (regAddr)
          `SACC_ADDR_CONTROL: regRdata <= control_reg;
          `SACC_ADDR_CONFIG: regRdata <= config_reg;
          `SACC_ADDR_RESULT: regRdata <= result_reg;
          `SACC_ADDR_FLAG: regRdata <= {1'b0, flag_reg, 6'h00};
          `SACC_ADDR_IRQEN: regRdata <= {1'b0, irqEnable_reg, 6'h00};
          `SACC_ADDR_GLOBAL: regRdata <= {globalEn_reg, periphEn_reg, 6'h00};
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // sacc_conv_ctrl

//--- hw/sacc_consts.vh
`ifndef SACC_CONSTS_VH
`define SACC_CONSTS_VH
// ******************************
// register offsets
// ******************************
`define SACC_ADDR_CONTROL 8'h1F
`define SACC_ADDR_CONFIG 8'h9F
`define SACC_ADDR_RESULT 8'h1E
`define SACC_ADDR_FLAG 8'h0C
`define SACC_ADDR_IRQEN 8'h8C
`define SACC_ADDR_GLOBAL 8'h0B
// ******************************
// field positions
// ******************************
`define SACC_CTL_ENABLE 0
`define SACC_CTL_CHHI 1
`define SACC_CTL_START 2
`define SACC_CTL_CHLO 3
`define SACC_CTL_CLKLO 6
`define SACC_CTL_CLKHI 7
`define SACC_CFG_REFLO 4
`define SACC_CFG_REFHI 5
`define SACC_FLAG_BIT 6
`define SACC_IRQEN_BIT 6
`define SACC_GIE_BIT 7
`define SACC_PERIPHERAL_IRQ_ENABLE_BIT 6
// ******************************
// encodings and timing
// ******************************
`define SACC_REF_SUPPLY 2'h0
`define SACC_REF_EXTPIN 2'h1
`define SACC_REF_INTERNAL 2'h2
`define SACC_REF_DAC 2'h3
`define SACC_CLK_DIV2 2'h0
`define SACC_CLK_DIV8 2'h1
`define SACC_CLK_DIV32 2'h2
`define SACC_CLK_RC 2'h3
`define SACC_DIV2 6'h02
`define SACC_DIV8 6'h08
`define SACC_DIV32 6'h20
`define SACC_HALF_TICKS 5'h13
`define SACC_ABORT_TICKS 5'h04
`define SACC_DISC_TICKS 5'h02
`define SACC_RESET_CTL 8'h00
`define SACC_RESET_CFG 8'h00
`endif

//--- hw/sacc_tick_gen.v
`timescale 1ns/100ps
`include "sacc_consts.vh"
// ******************************
// conversion half-tick generator
// ******************************
module sacc_tick_gen
(
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // selection
  input wire [1:0] clockSelect,
  input wire rcClock,
  // one-cycle pulse at each half period
  output reg halfTick
);
  reg [5:0] divCnt_reg;
  reg [5:0] divLimit;
  reg rcSync1_reg;
  reg rcSync2_reg;
  reg rcSync3_reg;

  // live select, switch takes effect next tick
  always @*
  begin
    case (clockSelect)
      `SACC_CLK_DIV2: divLimit = `SACC_DIV2 >> 1;
      `SACC_CLK_DIV8: divLimit = `SACC_DIV8 >> 1;
      default: divLimit = `SACC_DIV32 >> 1;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      divCnt_reg <= 6'h00;
      rcSync1_reg <= 1'b0;
      rcSync2_reg <= 1'b0;
      rcSync3_reg <= 1'b0;
      halfTick <= 1'b0;
    end
    else
    begin
      rcSync1_reg <= rcClock;
      rcSync2_reg <= rcSync1_reg;
      rcSync3_reg <= rcSync2_reg;
      if (clockSelect == `SACC_CLK_RC)
      begin
        divCnt_reg <= 6'h00;
        halfTick <= rcSync2_reg ^ rcSync3_reg; // each rc edge
      end
      else if (divCnt_reg + 6'h01 >= divLimit)
      begin
        divCnt_reg <= 6'h00;
        halfTick <= 1'b1;
      end
      else
      begin
        divCnt_reg <= divCnt_reg + 6'h01;
        halfTick <= 1'b0;
      end
    end
  end
endmodule // sacc_tick_gen

//--- dv/sacc_afe_model.sv
`timescale 1ns/100ps
// ****
// analog front end: hold capacitor and comparator
// ****
module sacc_afe_model
(
  // clock and analog source
  input logic clk_sys,
  input logic [7:0] analogLevel,
  // converter side
  input logic holdConnect,
  input logic [7:0] trialCode,
  output logic compareIn
);
  logic [7:0] heldReg = 8'h00;
  // charge kept, never discharged
  // tracks only while the switch is closed
  always @(posedge clk_sys)
  begin
    if (holdConnect)
      heldReg <= analogLevel;
    compareIn <= (heldReg >= trialCode);
  end
endmodule // sacc_afe_model

//--- dv/sacc_conv_ctrl_checker.sv
`timescale 1ns/100ps
// ****
// port checker
// ****
module sacc_conv_ctrl_checker
(
  // clock and reset
  input logic clk_sys,
  input logic rst_n,
  // register port
  input logic [7:0] regAddr,
  input logic [7:0] regWdata,
  input logic regWrite,
  // analog front end
  input logic [1:0] referenceSelect,
  input logic [3:0] channelSelect,
  input logic holdConnect,
  input logic converterOn,
  // status
  input logic convBusy,
  input logic irqRequest
);
  logic [1:0] refReg;
  logic [7:0] ctlReg;
  logic [2:0] enReg;
  logic [1:0] ageReg;
  wire enAll = &enReg;
  // shadow of software writes
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      refReg <= 2'h0;
      ctlReg <= 8'h00;
      enReg <= 3'h0;
      ageReg <= 2'h3;
    end
    else
    begin
      if (regWrite)
        ageReg <= 2'h0;
      else if (ageReg != 2'h3)
        ageReg <= ageReg + 2'h1;
      if (regWrite && regAddr == 8'h9F)
        refReg <= regWdata[5:4];
      if (regWrite && regAddr == 8'h1F)
        ctlReg <= regWdata;
      if (regWrite && regAddr == 8'h8C)
        enReg[0] <= regWdata[6];
      if (regWrite && regAddr == 8'h0B)
        enReg[2:1] <= regWdata[7:6];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_ref_route: assert property (
    ageReg == 2'h3 |-> referenceSelect == refReg)
    else $error("reference select differs from config");
  chk_ctl_fields: assert property (
    ageReg == 2'h3 |-> channelSelect == {ctlReg[1], ctlReg[5:3]}
      && converterOn == ctlReg[0])
    else $error("channel or enable differs from control");
  chk_busy_min: assert property (
    $rose(convBusy) |-> convBusy [*8])
    else $error("conversion ended too early");
  chk_busy_bound: assert property (
    $rose(convBusy) |-> ##[8:1000] !convBusy)
    else $error("conversion never completed");
  chk_hold_open: assert property (
    convBusy && $past(convBusy) |-> !holdConnect)
    else $error("hold switch closed while converting");
  chk_gap_after: assert property (
    $fell(convBusy) |-> !holdConnect)
    else $error("acquisition resumed with no gap");
  chk_irq_gate: assert property (
    irqRequest |-> $past(enAll) || $past(enAll, 2))
    else $error("irq raised with an enable clear");
  chk_off_abort: assert property (
    $fell(converterOn) |-> ##[0:2] !convBusy)
    else $error("conversion survived converter off");
endmodule // sacc_conv_ctrl_checker
bind sacc_conv_ctrl sacc_conv_ctrl_checker sacc_conv_ctrl_checker_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite),
  .referenceSelect(referenceSelect), .channelSelect(channelSelect),
  .holdConnect(holdConnect), .converterOn(converterOn),
  .convBusy(convBusy), .irqRequest(irqRequest));

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  typedef struct packed
  {
    logic [1:0] refSel;
    logic [1:0] clkSel;
    logic [7:0] level;
    logic [8:0] expCyc;
    logic [5:0] expDisc;
  } sacc_row_t;
  sacc_row_t rows [4];
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic rcClock = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] analogLevel = 8'h00;
  logic [7:0] regRdata, trialCode, rd;
  logic [1:0] referenceSelect;
  logic [3:0] channelSelect;
  logic compareIn, holdConnect, converterOn, convBusy, irqRequest;
  int badCount = 0;
  int testsRun = 0;
  int n;
  // clocks: system and free-running rc
  initial forever #10 clk_sys = ~clk_sys;
  initial forever #107 rcClock = ~rcClock;
  sacc_conv_ctrl sacc_conv_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .rcClock(rcClock),
    .compareIn(compareIn), .referenceSelect(referenceSelect),
    .channelSelect(channelSelect), .holdConnect(holdConnect),
    .trialCode(trialCode), .converterOn(converterOn),
    .convBusy(convBusy), .irqRequest(irqRequest));
  sacc_afe_model sacc_afe_model_i (.clk_sys(clk_sys),
    .analogLevel(analogLevel), .holdConnect(holdConnect),
    .trialCode(trialCode), .compareIn(compareIn));
  task automatic results();
    $display("tests %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 rd = regRdata;
  endtask
  // cycles until busy drops, bounded
  task automatic waitIdle();
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    while ((n < 4 || convBusy !== 1'b0) && n < 2000);
    if (n >= 2000)
    begin
      badCount++;
      results();
    end
  endtask
  // cycles until acquisition resumes
  task automatic waitHold();
    n = 0;
    while (holdConnect !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  initial
  begin
    // div2 row too fast for real bits, so all-ones level
    // expCyc: shortest edge count to done, tick phase adds up to 16
    rows[0] = '{2'h0, 2'h0, 8'hFF, 9'd18, 6'd1};
    rows[1] = '{2'h1, 2'h1, 8'h00, 9'd73, 6'd7};
    rows[2] = '{2'h2, 2'h2, 8'hA5, 9'd289, 6'd31};
    rows[3] = '{2'h3, 2'h3, 8'h5A, 9'd96, 6'd9};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // one conversion per row
    for (int i = 0; i < 4; i++)
    begin
      analogLevel <= rows[i].level;
      wr(8'h9F, {2'h0, rows[i].refSel, 4'h0});
      wr(8'h1F, {rows[i].clkSel, 6'h01});
      repeat (20) @(posedge clk_sys);
      wr(8'h1F, {rows[i].clkSel, 6'h05});
      waitIdle();
      check(n >= rows[i].expCyc && n <= rows[i].expCyc + 16, 1);
      waitHold();
      check(n >= rows[i].expDisc && n < 200, 1);
      check(referenceSelect, rows[i].refSel);
      rdReg(8'h1E);
      check(rd, rows[i].level);
      rdReg(8'h0C);
      check(rd[6], 1'b1);
      rdReg(8'h1F);
      check(rd[2], 1'b0);
      check(irqRequest, 1'b0);
      wr(8'h0C, 8'h00);
      $display("row %0d done", i);
    end
    // interrupt gating, enables added one by one
    wr(8'h1F, 8'h05);
    waitIdle();
    wr(8'h8C, 8'h40);
    wr(8'h0B, 8'h80);
    repeat (3) @(posedge clk_sys);
    check(irqRequest, 1'b0);
    wr(8'h0B, 8'hC0);
    repeat (3) @(posedge clk_sys);
    check(irqRequest, 1'b1);
    wr(8'h0C, 8'h00);
    repeat (3) @(posedge clk_sys);
    check(irqRequest, 1'b0);
    $display("irq test done");
    // start in the same write that enables
    wr(8'h1F, 8'h00);
    wr(8'h1F, 8'h05);
    repeat (4) @(posedge clk_sys);
    check(convBusy, 1'b0);
    rdReg(8'h1F);
    check(rd, 8'h01);
    // abort keeps software-written result
    wr(8'h1E, 8'h3C);
    analogLevel <= 8'hC3;
    wr(8'h1F, 8'h81);
    repeat (20) @(posedge clk_sys);
    wr(8'h1F, 8'h85);
    repeat (100) @(posedge clk_sys);
    wr(8'h1F, 8'h81);
    waitIdle();
    check(n < 8, 1);
    waitHold();
    check(n >= 46 && n < 200, 1);
    rdReg(8'h1E);
    check(rd, 8'h3C);
    rdReg(8'h0C);
    check(rd[6], 1'b0);
    $display("abort test done");
    // div32 for upper bits, then switch to div2
    wr(8'h1F, 8'h85);
    repeat (190) @(posedge clk_sys);
    wr(8'h1F, 8'h05);
    waitIdle();
    check(n <= 16, 1);
    rdReg(8'h1E);
    check(rd[7:4], 4'hC);
    $display("speed test done");
    // reset in mid-conversion
    wr(8'h1F, 8'h85);
    repeat (50) @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check({convBusy, converterOn, holdConnect}, 3'h0);
    rdReg(8'h1F);
    check(rd, 8'h00);
    $display("reset test done");
    results();
  end
endmodule // tb_top
